// ===== testbench/wait_checker_assertions.sv
`timescale 1ns/1ps
// Protocol watch on the wait insertion ports
module wait_checker
  import wait_ctrl_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic [15:0] reg_addr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic bus_state_two_in,
  input wire logic external_access_in,
  input wire logic insert_wait_out,
  input wire logic wait_pin_select_out,
  input wire logic [1:0] wait_count_out,
  input wire logic [1:0] wait_mode_out
);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // Accepted off-chip request; pulses during waits are ignored
  sequence go_s;
    bus_state_two_in && external_access_in && !insert_wait_out;
  endsequence
  pin_select_a: assert property (wait_pin_select_out == wait_mode_out[1])
    else $error("pin select wrong");
  no_wait_a: assert property (go_s ##0 (wait_mode_out == MODE_NO_WAIT)
    |=> !insert_wait_out) else $error("wait in no-wait mode");
  on_chip_a: assert property (bus_state_two_in && !external_access_in
    && !insert_wait_out |=> !insert_wait_out) else $error("on-chip wait");
  zero_count_a: assert property (go_s ##0 (wait_count_out == 2'h0
    && wait_mode_out != MODE_PIN_WAIT) |=> !insert_wait_out)
    else $error("wait with zero count");
  prog_two_a: assert property (go_s ##0 (wait_mode_out == MODE_PROGRAMMABLE
    && wait_count_out == 2'h2) |=> insert_wait_out[*2] ##1 !insert_wait_out)
    else $error("programmable count wrong");
  auto_one_a: assert property (go_s ##0 (wait_mode_out == MODE_PIN_AUTO
    && wait_count_out == 2'h1) |=> ##1 !insert_wait_out)
    else $error("auto-wait overran");
  pin_min_a: assert property (go_s ##0 (wait_mode_out == MODE_PIN_WAIT
    && wait_count_out == 2'h1) |=> insert_wait_out) else $error("pin wait short");
  after_t2_a: assert property ($rose(insert_wait_out) |-> $past(bus_state_two_in))
    else $error("wait not after state two");
  rsv_read_a: assert property (reg_rd_in && reg_addr_in == WAIT_STATE_CONTROL_ADDR
    |=> reg_rdata_out[7:4] == RESERVED_READ_VALUE) else $error("reserved bits");
endmodule
bind wait_insertion_unit wait_checker chk_i (.*);

// ===== testbench/wait_device.sv
`timescale 1ns/1ps
// Slow device: pulls the wait pin low for a set number of cycles
module wait_device (
  input wire logic clk_sys_in,
  input wire logic start_in,
  input wire logic [7:0] hold_in,
  output logic wait_n_out
);
  logic [7:0] left = 8'h00;
  always @(posedge clk_sys_in) begin
    if (start_in) left <= hold_in;
    else if (left != 8'h00) left <= left - 8'h01;
  end
  // Pulled-up pin, so a released line reads high
  assign wait_n_out = (left == 8'h00);
endmodule

// ===== testbench/wait_insertion_unit_bench.sv
`timescale 1ns/1ps
module wait_insertion_unit_bench;
  import wait_ctrl_pkg::*;
  logic clk_sys_in = 1'b0, rst_n_in = 1'b0, reg_wr_in = 1'b0;
  logic reg_rd_in = 1'b0, bus_state_two_in = 1'b0, standby_in = 1'b0;
  logic external_access_in = 1'b0, start = 1'b0, wait_n_in;
  logic [15:0] reg_addr_in = 16'h0000;
  logic [7:0] reg_wdata_in = 8'h00, hold = 8'h00, reg_rdata_out;
  logic insert_wait_out, wait_pin_select_out;
  logic [1:0] wait_count_out, wait_mode_out;
  int miscompares = 0, total_checks = 0;
  always #2 clk_sys_in = ~clk_sys_in;
  wait_insertion_unit dut (.*);
  wait_device far (.clk_sys_in(clk_sys_in), .start_in(start),
    .hold_in(hold), .wait_n_out(wait_n_in));
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One register cycle; a read compares the data of the next cycle
  task bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= w;
    reg_rd_in <= !w;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    if (!w) begin
      // Read data stand only in the cycle after the strobe
      #1;
      chk(reg_rdata_out, d);
    end
  endtask
  // Pin goes low early enough to clear the two-flop synchroniser
  task cyc(input logic [3:0] mc, input logic e, input logic [7:0] h,
    input logic [7:0] exp);
    logic [7:0] n;
    n = 8'h00;
    bus(1'b1, WAIT_STATE_CONTROL_ADDR, {4'h0, mc});
    @(posedge clk_sys_in);
    #1;
    chk({4'h0, wait_mode_out, wait_count_out}, {4'h0, mc});
    @(posedge clk_sys_in);
    hold <= h;
    start <= 1'b1;
    @(posedge clk_sys_in);
    start <= 1'b0;
    repeat (3) @(posedge clk_sys_in);
    bus_state_two_in <= 1'b1;
    external_access_in <= e;
    @(posedge clk_sys_in);
    bus_state_two_in <= 1'b0;
    repeat (40) begin
      @(posedge clk_sys_in);
      if (insert_wait_out === 1'b1) n++;
    end
    chk(n, exp);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    bus(1'b0, WAIT_STATE_CONTROL_ADDR, 8'hF3);
    bus(1'b1, WAIT_STATE_CONTROL_ADDR, 8'h0E);
    bus(1'b0, WAIT_STATE_CONTROL_ADDR, 8'hFE);
    chk({7'h00, wait_pin_select_out}, 8'h01);
    standby_in <= 1'b1;
    bus(1'b0, WAIT_STATE_CONTROL_ADDR, 8'hFE);
    standby_in <= 1'b0;
    bus(1'b0, 16'hFF11, UNMAPPED_READ_VALUE);
    cyc(4'h2, 1'b1, 8'h14, 8'h02);
    cyc(4'h7, 1'b1, 8'h14, 8'h00);
    cyc(4'h3, 1'b0, 8'h00, 8'h00);
    cyc(4'h0, 1'b1, 8'h00, 8'h00);
    cyc(4'hB, 1'b1, 8'h00, 8'h03);
    cyc(4'h9, 1'b1, 8'h04, 8'h03);
    cyc(4'h8, 1'b1, 8'h06, 8'h05);
    cyc(4'hD, 1'b1, 8'h14, 8'h01);
    cyc(4'hE, 1'b1, 8'h00, 8'h00);
    give_verdict;
  end
endmodule

// ===== verilog/wait_ctrl_pkg.sv
package wait_ctrl_pkg;
  // Register map and field layout
  localparam logic [15:0] WAIT_STATE_CONTROL_ADDR = 16'hFF10;
  localparam logic [7:0] WAIT_STATE_CONTROL_RESET = 8'hF3;
  localparam logic [3:0] RESERVED_READ_VALUE = 4'hF;
  localparam int MODE_LSB = 2;
  localparam int COUNT_LSB = 0;
  localparam logic [1:0] MODE_PROGRAMMABLE = 2'h0;
  localparam logic [1:0] MODE_NO_WAIT = 2'h1;
  localparam logic [1:0] MODE_PIN_WAIT = 2'h2;
  localparam logic [1:0] MODE_PIN_AUTO = 2'h3;
  localparam logic [7:0] UNMAPPED_READ_VALUE = 8'h00;
  localparam int SYNC_STAGES = 2;
endpackage

// ===== verilog/wait_insertion_unit.sv
// The strobed register port was decided locally.
`timescale 1ns/1ps
// How it works
// RULE1 - Reset loads the control register with programmable mode and three waits.
// RULE2 - Standby never touches the control register; only reset clears it.
// RULE3 - The upper four bits ignore writes and always read as ones.
// RULE4 - Bits 3:2 pick the mode: programmable, none, pin wait, pin auto-wait.
// RULE5 - Mode 01 inserts no wait states whatever the count is.
// RULE6 - Bits 1:0 hold a wait count from zero to three.
// RULE7 - A zero count inserts nothing except in pin wait mode.
// RULE8 - Only external CPU or transfer controller cycles are stretched.
// RULE9 - Programmable mode inserts exactly the counted waits.
// RULE10 - Programmable mode ignores the wait pin, leaving it general I/O.
// RULE11 - Both pin modes switch the shared port pin to its wait function.
// RULE12 - Pin wait mode adds the counted waits and more while the pin is low.
// RULE13 - Pin wait with zero count waits from bus_state_two while pin is low.
// RULE14 - Auto-wait samples the pin once in bus_state_two to choose the count.
// RULE15 - Auto-wait ignores the pin during waits and bus_state_three.
// RULE16 - Waits sit between bus_state_two and bus_state_three.
// RULE17 - After the counted waits, pin wait mode re-samples once per wait.
module wait_insertion_unit
  import wait_ctrl_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Register port
  input wire logic [15:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [7:0] reg_rdata_out,
  // Bus sequencer handshake
  input wire logic bus_state_two_in,
  input wire logic external_access_in,
  input wire logic standby_in,
  // Raw wait pin, active low, from the pad
  input wire logic wait_n_in,
  output logic insert_wait_out,
  output logic wait_pin_select_out,
  output logic [1:0] wait_count_out,
  output logic [1:0] wait_mode_out
);

  typedef enum logic [1:0] {IDLE, COUNTED, PIN_HOLD} wait_state_e;

  logic [1:0] mode;
  logic [1:0] count;
  logic [1:0] next_mode;
  logic [1:0] next_count;
  logic [7:0] next_rdata;
  logic wait_n_sync;
  wait_state_e state;
  wait_state_e next_state;
  logic [1:0] remain;
  logic [1:0] next_remain;
  logic next_insert;
  logic pin_low;
  logic pin_mode;

  // Wait pin crosses from the pad into the system clock domain
  wait_pin_sync u_sync (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .async_in(wait_n_in),
    .sync_out(wait_n_sync)
  );

  // Control register write; standby input is deliberately not used here
  always_comb begin
    next_mode = mode;
    next_count = count;
    if (reg_wr_in && reg_addr_in == WAIT_STATE_CONTROL_ADDR) begin
      next_mode = reg_wdata_in[MODE_LSB +: 2]; // [RULE4]
      next_count = reg_wdata_in[COUNT_LSB +: 2]; // [RULE6]
    end
  end

  // Read data one cycle after the strobe; upper nibble fixed ones
  always_comb begin
    next_rdata = UNMAPPED_READ_VALUE;
    if (reg_rd_in && reg_addr_in == WAIT_STATE_CONTROL_ADDR) begin
      next_rdata = {RESERVED_READ_VALUE, mode, count}; // [RULE3]
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // Only reset initialises; standby keeps contents [RULE1] [RULE2]
      mode <= WAIT_STATE_CONTROL_RESET[MODE_LSB +: 2];
      count <= WAIT_STATE_CONTROL_RESET[COUNT_LSB +: 2];
      reg_rdata_out <= UNMAPPED_READ_VALUE;
    end else begin
      mode <= next_mode;
      count <= next_count;
      reg_rdata_out <= next_rdata;
    end
  end

  assign pin_low = !wait_n_sync;
  // Pin modes claim the shared port pin [RULE11]
  assign pin_mode = mode[1];

  // Wait sequencer: decision taken in bus_state_two, waits follow [RULE16]
  always_comb begin
    next_state = state;
    next_remain = remain;
    next_insert = 1'b0;
    unique case (state)
      IDLE: begin
        // Only external cycles get waits [RULE8]
        if (bus_state_two_in && external_access_in) begin
          unique case (mode)
            MODE_PROGRAMMABLE: begin
              // Pin ignored here [RULE9] [RULE10] [RULE7]
              if (count != 2'h0) begin
                next_state = COUNTED;
                next_remain = count - 2'h1;
                next_insert = 1'b1;
              end
            end
            MODE_NO_WAIT: begin
              next_state = IDLE; // [RULE5]
            end
            MODE_PIN_WAIT: begin
              if (count != 2'h0) begin
                next_state = COUNTED; // [RULE12]
                next_remain = count - 2'h1;
                next_insert = 1'b1;
              end else if (pin_low) begin
                next_state = PIN_HOLD; // [RULE13]
                next_insert = 1'b1;
              end
            end
            MODE_PIN_AUTO: begin
              // Single sample of the pin; sync delay stands in for edge
              if (pin_low && count != 2'h0) begin
                next_state = COUNTED; // [RULE14] [RULE7]
                next_remain = count - 2'h1;
                next_insert = 1'b1;
              end
            end
          endcase
        end
      end
      COUNTED: begin
        if (remain != 2'h0) begin
          next_remain = remain - 2'h1;
          next_insert = 1'b1;
        end else if (mode == MODE_PIN_WAIT && pin_low) begin
          next_state = PIN_HOLD; // [RULE12] [RULE17]
          next_insert = 1'b1;
        end else begin
          next_state = IDLE; // Auto-wait never extends [RULE15]
        end
      end
      PIN_HOLD: begin
        // One re-sample per wait state [RULE17]
        if (pin_low) begin
          next_insert = 1'b1;
        end else begin
          next_state = IDLE;
        end
      end
      // The fourth enum code is unreachable; fall back to idle if upset
      default: begin
        next_state = IDLE;
        next_remain = 2'h0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= IDLE;
      remain <= 2'h0;
      insert_wait_out <= 1'b0;
      wait_pin_select_out <= 1'b0;
      wait_count_out <= WAIT_STATE_CONTROL_RESET[COUNT_LSB +: 2];
      wait_mode_out <= WAIT_STATE_CONTROL_RESET[MODE_LSB +: 2];
    end else begin
      state <= next_state;
      remain <= next_remain;
      insert_wait_out <= next_insert;
      wait_pin_select_out <= pin_mode; // [RULE11]
      wait_count_out <= count;
      wait_mode_out <= mode;
    end
  end

endmodule

// ===== verilog/wait_pin_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for the external wait pin
module wait_pin_sync
  import wait_ctrl_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic async_in,
  output logic sync_out
);
  logic [SYNC_STAGES-1:0] stage;
  logic [SYNC_STAGES-1:0] next_stage;

  // Shift chain; idle level is high so reset presets ones
  always_comb begin
    next_stage = {stage[SYNC_STAGES-2:0], async_in};
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage <= '1;
    end else begin
      stage <= next_stage;
    end
  end

  assign sync_out = stage[SYNC_STAGES-1];
endmodule
